// ### rtl/rssu_defines.vh
`ifndef RSSU_DEFINES_VH
`define RSSU_DEFINES_VH

// Register byte addresses
`define RSSU_ADDR_STATUS     32'hBF80F600
`define RSSU_ADDR_STAT_CLR   32'hBF80F604
`define RSSU_ADDR_STAT_SET   32'hBF80F608
`define RSSU_ADDR_STAT_INV   32'hBF80F60C
`define RSSU_ADDR_SOFT_RESET_ARM_BIT      32'hBF80F610
`define RSSU_ADDR_SOFT_RESET_ARM_BIT_CLR  32'hBF80F614
`define RSSU_ADDR_SOFT_RESET_ARM_BIT_SET  32'hBF80F618
`define RSSU_ADDR_SOFT_RESET_ARM_BIT_INV  32'hBF80F61C
`define RSSU_ADDR_UNLOCK     32'hBF80F620

// Status and soft reset arm field positions
`define RSSU_BIT_CMR         9
`define RSSU_BIT_VREG        8
`define RSSU_BIT_PIN_RESET_FLAG        7
`define RSSU_BIT_SWR         6
`define RSSU_BIT_WATCHDOG_EXPIRY_FLAG        4
`define RSSU_BIT_SLEEP       3
`define RSSU_BIT_IDLE        2
`define RSSU_BIT_BOR         1
`define RSSU_BIT_POR         0
`define RSSU_BIT_ARM         0

// Reset values and implemented bits
`define RSSU_STATUS_RST      32'h00000003
`define RSSU_STATUS_IMPL     32'h000003DF
`define RSSU_SOFT_RESET_ARM_BIT_IMPL      32'h00000001

// Unlock keys
`define RSSU_KEY1            32'hAA996655
`define RSSU_KEY2            32'h556699AA

// Timing counts in system clock cycles
`define RSSU_FETCH_DLY_CYC   4'h8
`define RSSU_PIN_FILT_CYC    3'h4

// Bus response codes
`define RSSU_RESP_OKAY       2'h0
`define RSSU_RESP_SLVERR     2'h2

// Write operation codes of the alias sets
`define RSSU_OP_WRITE        2'h0
`define RSSU_OP_CLR          2'h1
`define RSSU_OP_SET          2'h2
`define RSSU_OP_INV          2'h3

`endif

// ### rtl/rssu_sync.v
`timescale 1ns/10ps
module rssu_sync #(
	parameter RST_VAL = 1'b0
) (
	input  wire aclk,
	input  wire aresetn,
	input  wire din,
	output reg  dout
);

	reg meta_r;

	// Two-stage synchroniser, first stage read only by second
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= RST_VAL;
			dout   <= RST_VAL;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule

// ### rtl/rssu_top.v
// Summary of operation
// [R01] All reset sources merge into one master system reset output.
// [R02] Configuration mismatch reset sets status bit 9; only software clears it.
// [R03] Status bit 8 keeps regulator active in sleep when one, standby when zero.
// [R04] External pin reset sets status bit 7; only software clears it.
// [R05] Software reset sets status bit 6; hardware sets, software clears.
// [R06] Watchdog time-out sets status bit 4 until software clears it.
// [R07] Wake from sleep sets status bit 3; only software clears it.
// [R08] Software setting a status flag only stores it, never resets.
// [R09] Power-on leaves brown-out and power-on flags one, others zero.
// [R10] Status bits 31..10 and 5 are reserved, read zero, ignored.
// [R11] Status clear alias clears the written one bits; read undefined.
// [R12] Status set alias sets the written one bits; read undefined.
// [R13] Soft reset clear alias clears selected bits; read undefined.
// [R14] Soft reset set alias sets selected bits; read undefined.
// [R15] Software clears a cause flag to see a later occurrence.
// [R16] Arm bit set, then a read of soft reset register resets next cycle.
// [R17] Arm bit writes are ignored unless the system is unlocked.
// [R18] Unlock needs key one then key two, back to back, no access between.
// [R19] Reset released when configured and clocks stable; fetch 8 cycles later.
// [R20] Invert aliases toggle selected bits of their target; read undefined.
// [R21] Only bit 0 of the soft reset register exists, as the arm bit.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "rssu_defines.vh"
module rssu_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [31:0] s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        external_reset_pin_n,
	input  wire        brownout_event,
	input  wire        config_loaded,
	input  wire        clocks_stable,
	input  wire        watchdog_reset_source,
	input  wire        config_mismatch_event,
	input  wire        cpu_in_sleep,
	input  wire        cpu_in_idle,
	input  wire        wake_from_sleep,
	input  wire        wake_from_idle,
	output wire        master_system_reset,
	output wire        cpu_fetch_enable,
	output wire        regulator_standby_ctl
);

	localparam ST_HOLD = 3'h1;
	localparam ST_DLY  = 3'h2;
	localparam ST_RUN  = 3'h4;

	// Address decode: 0..7 table entries, 8 unlock key, F unmapped
	function [3:0] rssu_decode;
		input [31:0] a;
		begin
			if (a == `RSSU_ADDR_UNLOCK)
				rssu_decode = 4'h8;
			else if (a[31:5] == `RSSU_ADDR_STATUS >> 5 && a[1:0] == 2'h0)
				rssu_decode = {1'b0, a[4:2]};
			else
				rssu_decode = 4'hF;
		end
	endfunction

	// Plain write, clear, set or invert of masked bits
	function [31:0] rssu_merge;
		input [31:0] old;
		input [31:0] d;
		input [31:0] m;
		input [1:0]  op;
		begin
			case (op)
				`RSSU_OP_WRITE: rssu_merge = (old & ~m) | (d & m);
				`RSSU_OP_CLR:   rssu_merge = old & ~(d & m);
				`RSSU_OP_SET:   rssu_merge = old | (d & m);
				default:        rssu_merge = old ^ (d & m);
			endcase
		end
	endfunction

	// Synchronised pin and analog inputs
	wire pin_n_s;
	wire bor_s;
	wire cfg_s;
	wire clk_ok_s;

	rssu_sync #(.RST_VAL(1'b1)) u_sync_pin (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (external_reset_pin_n),
		.dout    (pin_n_s)
	);

	rssu_sync #(.RST_VAL(1'b0)) u_sync_bor (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (brownout_event),
		.dout    (bor_s)
	);

	rssu_sync #(.RST_VAL(1'b0)) u_sync_cfg (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (config_loaded),
		.dout    (cfg_s)
	);

	rssu_sync #(.RST_VAL(1'b0)) u_sync_clk (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (clocks_stable),
		.dout    (clk_ok_s)
	);

	// Bus state
	reg        aw_got_r;
	reg        w_got_r;
	reg [31:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0]  wstrb_r;
	reg        bvalid_r;
	reg [1:0]  bresp_r;
	reg        rvalid_r;
	reg [1:0]  rresp_r;
	reg [31:0] rdata_r;

	// Block state
	reg [31:0] status_r;
	reg [31:0] status_nxt;
	reg        arm_r;
	reg        arm_nxt;
	reg        unlocked_r;
	reg        unlocked_nxt;
	reg        key1_r;
	reg        key1_nxt;
	reg        swr_pend_r;
	reg [2:0]  pin_cnt_r;
	reg        pin_rst_r;
	reg [2:0]  state_r;
	reg [2:0]  state_nxt;
	reg [3:0]  dly_r;
	reg [3:0]  dly_nxt;
	reg        master_system_reset_r;
	reg        master_system_reset_nxt;
	reg        fetch_r;
	reg        fetch_nxt;

	wire        aw_hs   = s_axi_awvalid & s_axi_awready;
	wire        w_hs    = s_axi_wvalid & s_axi_wready;
	wire        ar_hs   = s_axi_arvalid & s_axi_arready;
	wire        wr_fire = aw_got_r & w_got_r & ~bvalid_r;
	wire [3:0]  wsel    = rssu_decode(awaddr_r);
	wire [3:0]  rsel    = rssu_decode(s_axi_araddr);
	wire [31:0] wmask   = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	wire        wr_stat = wr_fire & (wsel[3:2] == 2'h0);
	wire        wr_swr  = wr_fire & (wsel[3:2] == 2'h1);
	wire        wr_key  = wr_fire & (wsel == 4'h8);

	assign s_axi_awready = ~aw_got_r & ~bvalid_r;
	assign s_axi_wready  = ~w_got_r & ~bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

	assign master_system_reset   = master_system_reset_r;
	assign cpu_fetch_enable      = fetch_r;
	assign regulator_standby_ctl = status_r[`RSSU_BIT_VREG]; // [R03]

	// Watchdog in sleep or idle wakes the core instead of resetting
	wire wdt_reset = watchdog_reset_source & ~cpu_in_sleep & ~cpu_in_idle;
	wire wdt_wake  = watchdog_reset_source & (cpu_in_sleep | cpu_in_idle);

	// Merged reset request from every source
	wire reset_req = pin_rst_r | bor_s | config_mismatch_event | wdt_reset | swr_pend_r; // [R01]

	// Hardware flag sets
	reg [31:0] hw_set;
	always @* begin
		hw_set = 32'h00000000;
		hw_set[`RSSU_BIT_CMR]   = config_mismatch_event; // [R02]
		hw_set[`RSSU_BIT_PIN_RESET_FLAG]  = pin_rst_r; // [R04]
		hw_set[`RSSU_BIT_SWR]   = swr_pend_r; // [R05]
		hw_set[`RSSU_BIT_WATCHDOG_EXPIRY_FLAG]  = watchdog_reset_source; // [R06]
		hw_set[`RSSU_BIT_SLEEP] = wake_from_sleep | (wdt_wake & cpu_in_sleep); // [R07]
		hw_set[`RSSU_BIT_IDLE]  = wake_from_idle | (wdt_wake & cpu_in_idle);
		hw_set[`RSSU_BIT_BOR]   = bor_s;
	end

	// Pin low must persist for the filter count to count as a reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_cnt_r <= 3'h0;
			pin_rst_r <= 1'b0;
		end else if (pin_n_s) begin
			pin_cnt_r <= 3'h0;
			pin_rst_r <= 1'b0;
		end else if (pin_cnt_r == `RSSU_PIN_FILT_CYC - 3'h1) begin
			pin_rst_r <= 1'b1; // [R04]
		end else begin
			pin_cnt_r <= pin_cnt_r + 3'h1;
		end
	end

	// Status and soft reset register updates
	wire [31:0] stat_wr = rssu_merge(status_r, wdata_r, wmask & `RSSU_STATUS_IMPL, wsel[1:0]);
	wire [31:0] swr_wr  = rssu_merge({31'h0, arm_r}, wdata_r, wmask & `RSSU_SOFT_RESET_ARM_BIT_IMPL, wsel[1:0]);

	always @* begin
		status_nxt = status_r;
		if (wr_stat)
			status_nxt = stat_wr; // [R08] [R10] [R11] [R12] [R20]
		status_nxt = status_nxt | hw_set; // [R15]
	end

	always @* begin
		arm_nxt = arm_r;
		if (wr_swr && unlocked_r)
			arm_nxt = swr_wr[`RSSU_BIT_ARM]; // [R13] [R14] [R17] [R20] [R21]
		if (master_system_reset_r)
			arm_nxt = 1'b0;
	end

	// Unlock sequence: any other access between keys breaks it
	always @* begin
		key1_nxt     = key1_r;
		unlocked_nxt = unlocked_r;
		if (wr_key) begin
			if (wdata_r == `RSSU_KEY1) begin
				key1_nxt = 1'b1;
			end else if (key1_r && wdata_r == `RSSU_KEY2) begin
				key1_nxt     = 1'b0;
				unlocked_nxt = 1'b1; // [R18]
			end else begin
				key1_nxt     = 1'b0;
				unlocked_nxt = 1'b0;
			end
		end else if (wr_fire || ar_hs) begin
			key1_nxt = 1'b0; // [R18]
		end
		if (master_system_reset_r) begin
			key1_nxt     = 1'b0;
			unlocked_nxt = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			status_r   <= `RSSU_STATUS_RST; // [R09]
			arm_r      <= 1'b0;
			key1_r     <= 1'b0;
			unlocked_r <= 1'b0;
		end else begin
			status_r   <= status_nxt;
			arm_r      <= arm_nxt;
			key1_r     <= key1_nxt;
			unlocked_r <= unlocked_nxt;
		end
	end

	// Write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awaddr_r <= 32'h00000000;
			wdata_r  <= 32'h00000000;
			wstrb_r  <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r  <= `RSSU_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= (wsel == 4'hF) ? `RSSU_RESP_SLVERR : `RSSU_RESP_OKAY;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Read data mux; aliases read as zero
	reg [31:0] rmux;
	always @* begin
		case (rsel)
			4'h0:    rmux = status_r & `RSSU_STATUS_IMPL; // [R10]
			4'h4:    rmux = {31'h0, arm_r};
			4'h8:    rmux = {31'h0, unlocked_r};
			default: rmux = 32'h00000000; // [R11] [R12] [R13] [R14] [R20]
		endcase
	end

	// Read channel; a read of the armed register launches soft reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r   <= 1'b0;
			rresp_r    <= `RSSU_RESP_OKAY;
			rdata_r    <= 32'h00000000;
			swr_pend_r <= 1'b0;
		end else begin
			swr_pend_r <= 1'b0;
			if (ar_hs) begin
				rvalid_r <= 1'b1;
				rdata_r  <= rmux;
				rresp_r  <= (rsel == 4'hF) ? `RSSU_RESP_SLVERR : `RSSU_RESP_OKAY;
				if (rsel == 4'h4 && arm_r)
					swr_pend_r <= 1'b1; // [R16]
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Reset sequencer
	always @* begin
		state_nxt  = state_r;
		dly_nxt    = dly_r;
		master_system_reset_nxt = master_system_reset_r;
		fetch_nxt  = fetch_r;
		case (state_r)
			ST_HOLD: begin
				master_system_reset_nxt = 1'b1;
				fetch_nxt  = 1'b0;
				dly_nxt    = 4'h0;
				if (!reset_req && cfg_s && clk_ok_s) begin
					state_nxt  = ST_DLY;
					master_system_reset_nxt = 1'b0; // [R19]
					dly_nxt    = 4'h1;
				end
			end
			ST_DLY: begin
				if (dly_r == `RSSU_FETCH_DLY_CYC) begin
					state_nxt = ST_RUN;
					fetch_nxt = 1'b1; // [R19]
				end else begin
					dly_nxt = dly_r + 4'h1;
				end
			end
			ST_RUN: begin
				fetch_nxt = 1'b1;
			end
			default: begin
				state_nxt  = ST_HOLD;
				master_system_reset_nxt = 1'b1;
				fetch_nxt  = 1'b0;
			end
		endcase
		if (reset_req) begin
			state_nxt  = ST_HOLD;
			master_system_reset_nxt = 1'b1; // [R01]
			fetch_nxt  = 1'b0;
			dly_nxt    = 4'h0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r  <= ST_HOLD;
			dly_r    <= 4'h0;
			master_system_reset_r <= 1'b1;
			fetch_r  <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			dly_r    <= dly_nxt;
			master_system_reset_r <= master_system_reset_nxt;
			fetch_r  <= fetch_nxt;
		end
	end

endmodule

// ### dv/rssu_properties.sv
`timescale 1ns/10ps
module rssu_properties (
	input wire	aclk,
	input wire	aresetn,
	input wire	s_axi_bvalid,
	input wire	config_loaded,
	input wire	watchdog_reset_source,
	input wire	config_mismatch_event,
	input wire	brownout_event,
	input wire	external_reset_pin_n,
	input wire	cpu_in_sleep,
	input wire	cpu_in_idle,
	input wire	master_system_reset,
	input wire	cpu_fetch_enable,
	input wire	regulator_standby_ctl
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Eight idle cycles, then fetch
	sequence fetch_wait_s;
		!cpu_fetch_enable [*8] ##1 cpu_fetch_enable;
	endsequence
	sequence pin_low_s;
		!external_reset_pin_n [*8];
	endsequence
	fetch_delay_a: assert property ($fell(master_system_reset) |-> fetch_wait_s)
		else $error("fetch enable not eight cycles after release");
	fetch_off_a: assert property (master_system_reset |-> !cpu_fetch_enable)
		else $error("fetch enabled during reset");
	cfg_hold_a: assert property (!config_loaded [*4] |=> master_system_reset)
		else $error("reset released without configuration");
	cmr_rst_a: assert property (config_mismatch_event |-> ##[1:2] master_system_reset)
		else $error("mismatch did not reset");
	wdg_rst_a: assert property (watchdog_reset_source && !cpu_in_sleep && !cpu_in_idle
		|-> ##[1:2] master_system_reset) else $error("watchdog did not reset");
	bor_rst_a: assert property (brownout_event [*3] |-> ##[0:2] master_system_reset)
		else $error("brownout did not reset");
	pin_rst_a: assert property (pin_low_s |-> ##[0:2] master_system_reset)
		else $error("pin did not reset");
	vreg_hold_a: assert property ($changed(regulator_standby_ctl) |-> $rose(s_axi_bvalid))
		else $error("regulator control changed without write");
endmodule
bind rssu_top rssu_properties rssu_properties_inst (.aclk, .aresetn, .s_axi_bvalid, .config_loaded,
	.watchdog_reset_source, .config_mismatch_event, .brownout_event, .external_reset_pin_n,
	.cpu_in_sleep, .cpu_in_idle, .master_system_reset, .cpu_fetch_enable, .regulator_standby_ctl);

// ### dv/rssu_top_tb.sv
`timescale 1ns/10ps
`include "rssu_defines.vh"
module rssu_top_tb;
	localparam [159:0]	EXP = {32'h8, 32'h2, 32'h80, 32'h200, 32'h10};
	reg		aclk;
	reg		aresetn = 0;
	reg [31:0]	s_axi_awaddr = 0;
	reg [31:0]	s_axi_wdata = 0;
	reg [31:0]	s_axi_araddr = 0;
	reg [2:0]	s_axi_awprot = 0;
	reg [2:0]	s_axi_arprot = 0;
	reg [3:0]	s_axi_wstrb = 4'hF;
	reg		s_axi_awvalid = 0;
	reg		s_axi_wvalid = 0;
	reg		s_axi_bready = 0;
	reg		s_axi_arvalid = 0;
	reg		s_axi_rready = 0;
	reg		config_loaded = 0;
	reg		cpu_in_sleep = 0;
	reg		cpu_in_idle = 0;
	reg		wake_from_idle = 0;
	reg [4:0]	src = 0;
	wire		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]	s_axi_bresp, s_axi_rresp;
	wire [31:0]	s_axi_rdata;
	wire		master_system_reset, cpu_fetch_enable, regulator_standby_ctl, clocks_stable;
	wire		watchdog_reset_source, config_mismatch_event, brownout_event, wake_from_sleep;
	wire		external_reset_pin_n;
	integer		errors = 0;
	integer		checks_done = 0;
	integer		seed = 32'hC60B;
	integer		i;
	reg [34:0]	q[$];
	reg [34:0]	e;
	reg [31:0]	r;
	assign {wake_from_sleep, brownout_event, config_mismatch_event, watchdog_reset_source} = {src[4:3], src[1:0]};
	assign external_reset_pin_n = !src[2];
	assign clocks_stable = config_loaded;
	rssu_top rssu_top_inst (.*);
	initial begin
		aclk = 0;
		forever #2.5 aclk = ~aclk;
	end
	task print_verdict;
		begin
			$display("errors=%0d checks=%0d", errors, checks_done);
			if (errors == 0 && checks_done > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task chk(input c);
		begin
			checks_done++;
			if (!c) begin
				errors++;
				$display("[FAIL] %0t output level wrong", $time);
			end
		end
	endtask
	// One bus access; expected answer queued for the monitor
	task bus(input w, input [31:0] a, input [31:0] d, input [1:0] rsp);
		begin
			@(posedge aclk);
			q.push_back({!w, rsp, w ? 32'h0 : d});
			if (w) begin
				s_axi_awaddr <= a;
				s_axi_wdata <= d;
				s_axi_awvalid <= 1'b1;
				s_axi_wvalid <= 1'b1;
				s_axi_bready <= 1'b1;
			end else begin
				s_axi_araddr <= a;
				s_axi_arvalid <= 1'b1;
				s_axi_rready <= 1'b1;
			end
			do begin
				@(posedge aclk);
				if (s_axi_awready)
					s_axi_awvalid <= 1'b0;
				if (s_axi_wready)
					s_axi_wvalid <= 1'b0;
				if (s_axi_arready)
					s_axi_arvalid <= 1'b0;
			end while (!(s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready));
			s_axi_bready <= 1'b0;
			s_axi_rready <= 1'b0;
		end
	endtask
	task settle;
		begin
			wait (master_system_reset === 1'b0);
			repeat (9) @(posedge aclk);
			chk(cpu_fetch_enable === 1'b1);
		end
	endtask
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready || s_axi_bvalid && s_axi_bready) begin
			e = q.pop_front();
			checks_done++;
			if ({s_axi_rvalid, s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}} !== e) begin
				errors++;
				$display("[FAIL] %0t bus answer %h", $time, e);
			end
		end
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (20) @(posedge aclk);
		chk(master_system_reset === 1'b1);
		config_loaded <= 1'b1;
		settle;
		bus(0, `RSSU_ADDR_STATUS, 32'h3, 0);
		bus(0, `RSSU_ADDR_SOFT_RESET_ARM_BIT, 0, 0);
		r = $random(seed);
		bus(1, `RSSU_ADDR_STATUS, r, 0);
		bus(0, `RSSU_ADDR_STATUS, r & 32'h3DF, 0);
		bus(1, `RSSU_ADDR_STAT_SET, 32'hFFFFFFFF, 0);
		chk(regulator_standby_ctl === 1'b1 && master_system_reset === 1'b0);
		bus(0, `RSSU_ADDR_STATUS, 32'h3DF, 0);
		bus(1, `RSSU_ADDR_STAT_CLR, 32'hFFFFFFFF, 0);
		bus(0, `RSSU_ADDR_STATUS, 0, 0);
		bus(1, `RSSU_ADDR_STAT_INV, 32'h105, 0);
		bus(0, `RSSU_ADDR_STATUS, 32'h105, 0);
		chk(regulator_standby_ctl === 1'b1);
		bus(1, 32'hBF80F630, 0, 2);
		bus(1, `RSSU_ADDR_STAT_CLR, 32'hFFFFFFFF, 0);
		s_axi_wstrb <= 4'h2;
		bus(1, `RSSU_ADDR_STAT_SET, 32'hFFFFFFFF, 0);
		s_axi_wstrb <= 4'hF;
		bus(0, `RSSU_ADDR_STATUS, 32'h300, 0);
		chk(regulator_standby_ctl === 1'b1);
		bus(1, `RSSU_ADDR_STAT_CLR, 32'hFFFFFFFF, 0);
		chk(regulator_standby_ctl === 1'b0);
		bus(1, `RSSU_ADDR_SOFT_RESET_ARM_BIT_SET, 1, 0);
		bus(0, `RSSU_ADDR_SOFT_RESET_ARM_BIT, 0, 0);
		bus(1, `RSSU_ADDR_UNLOCK, `RSSU_KEY1, 0);
		bus(0, `RSSU_ADDR_STATUS, 0, 0);
		bus(1, `RSSU_ADDR_UNLOCK, `RSSU_KEY2, 0);
		bus(1, `RSSU_ADDR_SOFT_RESET_ARM_BIT_SET, 1, 0);
		bus(0, `RSSU_ADDR_SOFT_RESET_ARM_BIT, 0, 0);
		bus(1, `RSSU_ADDR_UNLOCK, `RSSU_KEY1, 0);
		bus(1, `RSSU_ADDR_UNLOCK, `RSSU_KEY2, 0);
		bus(1, `RSSU_ADDR_SOFT_RESET_ARM_BIT_SET, 1, 0);
		bus(1, `RSSU_ADDR_SOFT_RESET_ARM_BIT_CLR, 1, 0);
		bus(0, `RSSU_ADDR_SOFT_RESET_ARM_BIT, 0, 0);
		bus(1, `RSSU_ADDR_SOFT_RESET_ARM_BIT_INV, 1, 0);
		bus(0, `RSSU_ADDR_SOFT_RESET_ARM_BIT, 1, 0);
		@(posedge aclk);
		chk(master_system_reset === 1'b1);
		settle;
		bus(0, `RSSU_ADDR_STATUS, 32'h40, 0);
		// Each source in turn: watchdog, mismatch, pin, brownout, wake
		for (i = 0; i < 5; i++) begin
			bus(1, `RSSU_ADDR_STAT_CLR, 32'hFFFFFFFF, 0);
			src <= 5'h1 << i;
			repeat (10) @(posedge aclk);
			src <= 5'h0;
			settle;
			bus(0, `RSSU_ADDR_STATUS, EXP[i*32 +: 32], 0);
		end
		// Watchdog in sleep wakes without reset
		bus(1, `RSSU_ADDR_STAT_CLR, 32'hFFFFFFFF, 0);
		cpu_in_sleep <= 1'b1;
		src <= 5'h1;
		repeat (4) @(posedge aclk);
		src <= 5'h0;
		cpu_in_sleep <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(master_system_reset === 1'b0 && cpu_fetch_enable === 1'b1);
		bus(0, `RSSU_ADDR_STATUS, 32'h18, 0);
		// Idle wake pulse, then watchdog in idle
		bus(1, `RSSU_ADDR_STAT_CLR, 32'hFFFFFFFF, 0);
		cpu_in_idle <= 1'b1;
		wake_from_idle <= 1'b1;
		@(posedge aclk);
		wake_from_idle <= 1'b0;
		src <= 5'h1;
		repeat (4) @(posedge aclk);
		src <= 5'h0;
		cpu_in_idle <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(master_system_reset === 1'b0);
		bus(0, `RSSU_ADDR_STATUS, 32'h14, 0);
		print_verdict;
	end
	initial begin
		#100000;
		errors++;
		print_verdict;
	end
endmodule
